/* verilog/presence_pkg.sv */
// Purpose: Shared constants for the presence decision and reporting block
// Assumes: 50 MHz system clock, plain register port with 8-bit byte addresses
// Notes:   All offsets are byte addresses of 32-bit words
package presence_pkg;
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned BAUD_DEF      = 256_000;
    localparam int unsigned NGATE         = 9;
    localparam int unsigned GATE_MAX_LIM  = 8;
    localparam int unsigned GATE_MIN_LIM  = 1;
    localparam int unsigned GATE_STEP_MM  = 750;
    localparam int unsigned ENERGY_MAX    = 100;
    localparam int unsigned SEC_MS        = 1000;
    localparam int unsigned SEC_CYCLES    = CLK_HZ / 1000 * SEC_MS;
    localparam int unsigned PWR_WIN_MS    = 2500;
    localparam int unsigned PWR_WIN_CYC   = CLK_HZ / 1000 * PWR_WIN_MS;
    localparam int unsigned PWR_CNT_TRIG  = 6;
    localparam logic [7:0]  ADR_CTRL      = 8'h00;
    localparam logic [7:0]  ADR_MOVE_MAX  = 8'h04;
    localparam logic [7:0]  ADR_STAT_MAX  = 8'h08;
    localparam logic [7:0]  ADR_ABS_SEC   = 8'h0c;
    localparam logic [7:0]  ADR_STATUS    = 8'h10;
    localparam logic [7:0]  ADR_IRQ_STAT  = 8'h14;
    localparam logic [7:0]  ADR_IRQ_MASK  = 8'h18;
    localparam logic [7:0]  ADR_SENS_BASE = 8'h40;
    localparam int unsigned CTRL_REPORT   = 0;
    localparam int unsigned CTRL_ENG      = 1;
    localparam int unsigned CTRL_WL_ON    = 2;
    localparam int unsigned CTRL_WL_OFF   = 3;
    localparam int unsigned CTRL_DEFAULTS = 4;
    localparam logic [3:0]  DEF_GATE_MAX  = 4'h8;
    localparam logic [15:0] DEF_ABS_SEC   = 16'h0005;
    localparam logic [6:0]  DEF_SENS      = 7'h32;
    localparam int unsigned IRQ_ARRIVE    = 0;
    localparam int unsigned IRQ_LEAVE     = 1;
    localparam int unsigned IRQ_REPORT    = 2;
    localparam int unsigned IRQ_WL_BACK   = 3;
    localparam int unsigned NIRQ          = 4;
    localparam int unsigned BASE_BYTES    = 3;
    typedef enum logic [1:0] {
        TGT_NONE   = 2'h0,
        TGT_MOVING = 2'h1,
        TGT_STATIC = 2'h2
    } target_t;
endpackage

/* verilog/serial_byte_if.sv */
// Purpose: Byte handshake between report sequencer and serial transmitter
// Assumes: Single clock domain
// Notes:   Byte is taken when valid and ready are both high
`timescale 1ns/1ps
`default_nettype none
interface serial_byte_if;
    logic [7:0] data;
    logic       valid;
    logic       ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

/* verilog/serial_tx.sv */
// Purpose: Serial transmitter, 8N1, LSB first
// Assumes: Baud enable derived from the system clock
// Notes:   Divisor rounds to the nearest whole cycle
`timescale 1ns/1ps
`default_nettype none
module serial_tx #(
    parameter int unsigned BAUD = presence_pkg::BAUD_DEF
) (
    input  wire logic      clk_sys_i,
    input  wire logic      rst_n_i,
    serial_byte_if.snk     byte_in,
    output logic           tx_o
);
    import presence_pkg::*;
    localparam int unsigned DIV = (CLK_HZ + BAUD / 2) / BAUD;
    logic [15:0] div_r;
    logic [3:0]  bit_r;
    logic [9:0]  shf_r;
    logic        busy_r;
    logic        tick;

    assign tick          = (div_r == 16'(DIV - 1));
    assign byte_in.ready = ~busy_r;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            div_r <= 16'h0000;
        else if (!busy_r || tick)
            div_r <= 16'h0000;
        else
            div_r <= div_r + 16'h0001;
    end

    // Start bit low, data LSB first, one stop bit, no parity
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_r <= 1'b0;
            bit_r  <= 4'h0;
            shf_r  <= 10'h3ff;
            tx_o   <= 1'b1;
        end
        else if (!busy_r && byte_in.valid)
        begin
            busy_r <= 1'b1;
            bit_r  <= 4'h0;
            shf_r  <= {1'b1, byte_in.data, 1'b0};
            tx_o   <= 1'b0;
        end
        else if (busy_r && tick)
        begin
            if (bit_r == 4'h9)
                busy_r <= 1'b0;
            else
            begin
                bit_r <= bit_r + 4'h1;
                tx_o  <= shf_r[bit_r + 4'h1];
            end
        end
    end

    a_tx_idle_high: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !busy_r |-> tx_o) else $error("line not idle high");
    a_tx_start_low: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (byte_in.valid && byte_in.ready) |=> !tx_o [*8]) else $error("start bit too short");
endmodule // serial_tx
`default_nettype wire

/* verilog/presence_decision_output.sv */
// Purpose: Gate threshold decision, absence hold, presence pin and serial reporting
// Assumes: Per-gate energies arrive on the system clock with a one-cycle valid
// Notes:   Configuration storage has no reset so it survives reset like retained memory
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module presence_decision_output #(
    parameter int unsigned SEC_CYC = presence_pkg::SEC_CYCLES,
    parameter int unsigned PWR_CYC = presence_pkg::PWR_WIN_CYC,
    parameter int unsigned BAUD    = presence_pkg::BAUD_DEF
) (
    input  wire logic                            clk_sys_i,
    input  wire logic                            rst_n_i,
    input  wire logic [7:0]                      addr_i,
    input  wire logic [31:0]                     wdata_i,
    input  wire logic                            wr_i,
    input  wire logic                            rd_i,
    output logic [31:0]                          rdata_o,
    input  wire logic [7*presence_pkg::NGATE-1:0] move_energy_i,
    input  wire logic [7*presence_pkg::NGATE-1:0] static_energy_i,
    input  wire logic                            energy_valid_i,
    input  wire logic                            power_on_i,
    output logic                                 presence_o,
    output logic                                 uart_tx_o,
    output logic                                 wireless_en_o,
    output logic                                 irq_o
);
    import presence_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [6:0]      sens_r [NGATE];
    logic [3:0]      move_max_r;
    logic [3:0]      stat_max_r;
    logic [15:0]     abs_sec_r;
    logic            report_r;
    logic            eng_r;
    logic [NIRQ-1:0] irq_stat_r;
    logic [NIRQ-1:0] irq_mask_r;
    logic [NIRQ-1:0] irq_ev;
    logic            cfg_ok;
    logic            cfg_wr;
    logic [3:0]      sens_idx;
    logic [3:0]      gmax_w;

    assign cfg_ok   = ~report_r;
    assign cfg_wr   = wr_i && cfg_ok;
    assign sens_idx = addr_i[5:2];
    assign gmax_w   = (wdata_i[3:0] < 4'(GATE_MIN_LIM)) ? 4'(GATE_MIN_LIM) :
                      (wdata_i[3:0] > 4'(GATE_MAX_LIM)) ? 4'(GATE_MAX_LIM) : wdata_i[3:0];

    // Retained storage: no reset, defaults restored only on command
    always_ff @(posedge clk_sys_i)
    begin
        if (wr_i && addr_i == ADR_CTRL && wdata_i[CTRL_DEFAULTS] && cfg_ok)
        begin
            move_max_r <= DEF_GATE_MAX;
            stat_max_r <= DEF_GATE_MAX;
            abs_sec_r  <= DEF_ABS_SEC;
            for (int g = 0; g < NGATE; g++)
                sens_r[g] <= DEF_SENS;
        end
        else if (cfg_wr)
        begin
            if (addr_i == ADR_MOVE_MAX)
                move_max_r <= gmax_w;
            if (addr_i == ADR_STAT_MAX)
                stat_max_r <= gmax_w;
            if (addr_i == ADR_ABS_SEC)
                abs_sec_r <= wdata_i[15:0];
            if (addr_i >= ADR_SENS_BASE && sens_idx < 4'(NGATE) && addr_i[7:6] == 2'h1)
                sens_r[sens_idx] <= (wdata_i[6:0] > 7'(ENERGY_MAX)) ? 7'(ENERGY_MAX) : wdata_i[6:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            report_r <= 1'b0;
            eng_r    <= 1'b0;
        end
        else if (wr_i && addr_i == ADR_CTRL)
        begin
            report_r <= wdata_i[CTRL_REPORT];
            eng_r    <= wdata_i[CTRL_ENG];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gate decision: nearest hitting gate gives the distance
    logic       move_hit;
    logic       stat_hit;
    logic [3:0] move_gate;
    logic [3:0] stat_gate;

    always_comb
    begin
        move_hit  = 1'b0;
        stat_hit  = 1'b0;
        move_gate = 4'h0;
        stat_gate = 4'h0;
        for (int g = NGATE - 1; g >= 0; g--)
        begin
            if (4'(g) <= move_max_r && move_energy_i[7*g +: 7] > sens_r[g])
            begin
                move_hit  = 1'b1;
                move_gate = 4'(g);
            end
            if (4'(g) <= stat_max_r && static_energy_i[7*g +: 7] > sens_r[g])
            begin
                stat_hit  = 1'b1;
                stat_gate = 4'(g);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Absence hold in whole seconds; the second divider restarts on each hit, so the hold runs the full count
    logic [31:0] sec_div_r;
    logic        sec_tick;
    logic [15:0] hold_r;
    target_t     tgt_r;
    logic [3:0]  mdist_r;
    logic [3:0]  sdist_r;
    logic        detect;

    assign sec_tick = (sec_div_r == SEC_CYC - 1);
    assign detect   = energy_valid_i && (move_hit || stat_hit);

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sec_div_r <= 32'h0000_0000;
        else if (sec_tick || detect)
            sec_div_r <= 32'h0000_0000;
        else
            sec_div_r <= sec_div_r + 32'h0000_0001;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hold_r     <= 16'h0000;
            presence_o <= 1'b0;
            tgt_r      <= TGT_NONE;
            mdist_r    <= 4'h0;
            sdist_r    <= 4'h0;
        end
        else if (detect)
        begin
            hold_r     <= abs_sec_r;
            presence_o <= 1'b1;
            tgt_r      <= move_hit ? TGT_MOVING : TGT_STATIC;
            mdist_r    <= move_gate;
            sdist_r    <= stat_gate;
        end
        else if (presence_o && sec_tick)
        begin
            if (hold_r <= 16'h0001)
            begin
                hold_r     <= 16'h0000;
                presence_o <= 1'b0;
                tgt_r      <= TGT_NONE;
            end
            else
                hold_r <= hold_r - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Report sequencer: status, distances, then energies in engineering mode
    typedef enum logic [1:0] {
        RPT_IDLE = 2'b01,
        RPT_SEND = 2'b10
    } rpt_state_t;

    rpt_state_t    rpt_r;
    logic [4:0]    idx_r;
    logic [4:0]    last_r;
    logic [7*NGATE-1:0] me_r;
    logic [7*NGATE-1:0] se_r;
    logic          rpt_done;
    serial_byte_if sb ();

    always_comb
    begin
        sb.data = 8'h00;
        if (idx_r == 5'h0)
            sb.data = {6'h00, tgt_r};
        else if (idx_r == 5'h1)
            sb.data = {4'h0, mdist_r};
        else if (idx_r == 5'h2)
            sb.data = {4'h0, sdist_r};
        else if (idx_r < 5'(BASE_BYTES + NGATE))
            sb.data = {1'b0, me_r[7*(idx_r - 5'(BASE_BYTES)) +: 7]};
        else
            sb.data = {1'b0, se_r[7*(idx_r - 5'(BASE_BYTES + NGATE)) +: 7]};
    end

    assign sb.valid = (rpt_r == RPT_SEND);
    assign rpt_done = sb.valid && sb.ready && (idx_r == last_r);

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rpt_r  <= RPT_IDLE;
            idx_r  <= 5'h0;
            last_r <= 5'h0;
            me_r   <= '0;
            se_r   <= '0;
        end
        else
        begin
            case (rpt_r)
                RPT_IDLE:
                    if (energy_valid_i && report_r)
                    begin
                        rpt_r  <= RPT_SEND;
                        idx_r  <= 5'h0;
                        last_r <= eng_r ? 5'(BASE_BYTES + 2 * NGATE - 1) : 5'(BASE_BYTES - 1);
                        me_r   <= move_energy_i;
                        se_r   <= static_energy_i;
                    end
                RPT_SEND:
                    if (rpt_done)
                        rpt_r <= RPT_IDLE;
                    else if (sb.ready)
                        idx_r <= idx_r + 5'h1;
                default:
                    rpt_r <= RPT_IDLE;
            endcase
        end
    end

    serial_tx #(.BAUD(BAUD)) u_tx (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .byte_in   (sb.snk),
        .tx_o      (uart_tx_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Power-on pulses pass three flops; window opens at the first edge
    logic [2:0]  pwr_sync_r;
    logic        pwr_lvl_r;
    logic [31:0] win_r;
    logic [2:0]  pcnt_r;
    logic        pwr_edge;
    logic        wl_back;

    assign pwr_edge = pwr_sync_r[2] && pwr_sync_r[1] && !pwr_lvl_r;
    assign wl_back  = pwr_edge && (pcnt_r == 3'(PWR_CNT_TRIG - 1)) && (win_r != 32'h0);

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pwr_sync_r <= 3'h0;
            pwr_lvl_r  <= 1'b0;
        end
        else
        begin
            pwr_sync_r <= {pwr_sync_r[1:0], power_on_i};
            // A change counts only once the last two stages agree
            if (pwr_sync_r[2] == pwr_sync_r[1])
                pwr_lvl_r <= pwr_sync_r[2];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            win_r  <= 32'h0000_0000;
            pcnt_r <= 3'h0;
        end
        else if (wl_back)
        begin
            win_r  <= 32'h0000_0000;
            pcnt_r <= 3'h0;
        end
        else if (pwr_edge)
        begin
            win_r  <= (win_r == 32'h0) ? PWR_CYC : win_r;
            pcnt_r <= (win_r == 32'h0) ? 3'h1 : pcnt_r + 3'h1;
        end
        else if (win_r != 32'h0)
        begin
            win_r  <= win_r - 32'h0000_0001;
            pcnt_r <= (win_r == 32'h1) ? 3'h0 : pcnt_r;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            wireless_en_o <= 1'b1;
        else if (wl_back)
            wireless_en_o <= 1'b1;
        else if (wr_i && addr_i == ADR_CTRL && wdata_i[CTRL_WL_OFF])
            wireless_en_o <= 1'b0;
        else if (wr_i && addr_i == ADR_CTRL && wdata_i[CTRL_WL_ON])
            wireless_en_o <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky events; a new event beats a same-cycle clear
    always_comb
    begin
        irq_ev              = '0;
        irq_ev[IRQ_ARRIVE]  = detect && !presence_o;
        irq_ev[IRQ_LEAVE]   = presence_o && sec_tick && !detect && (hold_r <= 16'h0001);
        irq_ev[IRQ_REPORT]  = rpt_done;
        irq_ev[IRQ_WL_BACK] = wl_back;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            irq_o      <= 1'b0;
        end
        else
        begin
            irq_stat_r <= (irq_stat_r & ~((wr_i && addr_i == ADR_IRQ_STAT) ? wdata_i[NIRQ-1:0] : '0)) | irq_ev;
            if (wr_i && addr_i == ADR_IRQ_MASK)
                irq_mask_r <= wdata_i[NIRQ-1:0];
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: parameters read as zero while reporting runs
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= 32'h0000_0000;
        else if (rd_i)
        begin
            rdata_o <= 32'h0000_0000;
            case (addr_i)
                ADR_CTRL:     rdata_o <= {27'h0, 1'b0, 1'b0, wireless_en_o, eng_r, report_r};
                ADR_MOVE_MAX: rdata_o <= cfg_ok ? {28'h0, move_max_r} : 32'h0;
                ADR_STAT_MAX: rdata_o <= cfg_ok ? {28'h0, stat_max_r} : 32'h0;
                ADR_ABS_SEC:  rdata_o <= cfg_ok ? {16'h0, abs_sec_r} : 32'h0;
                ADR_STATUS:   rdata_o <= {16'h0, sdist_r, mdist_r, 5'h0, presence_o, tgt_r};
                ADR_IRQ_STAT: rdata_o <= {28'h0, irq_stat_r};
                ADR_IRQ_MASK: rdata_o <= {28'h0, irq_mask_r};
                default:
                    if (cfg_ok && addr_i[7:6] == 2'h1 && sens_idx < 4'(NGATE))
                        rdata_o <= {25'h0, sens_r[sens_idx]};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_pin_follows_hit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        detect |=> presence_o) else $error("presence not raised on hit");
    a_pin_none_low: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        presence_o == (tgt_r != TGT_NONE)) else $error("pin and status disagree");
    a_gate_limit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        detect |=> (mdist_r <= move_max_r || !$past(move_hit))) else $error("gate beyond limit");
    a_max_range: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (cfg_wr && addr_i == ADR_MOVE_MAX) |=> (move_max_r >= 4'(GATE_MIN_LIM) && move_max_r <= 4'(GATE_MAX_LIM)))
        else $error("limit out of range");
    a_hold_keeps: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (presence_o && hold_r > 16'h1 && !sec_tick) |=> presence_o) else $error("dropped early");
    a_cfg_locked: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (report_r && wr_i && addr_i == ADR_ABS_SEC) |=> $stable(abs_sec_r)) else $error("write while reporting");
    a_rpt_length: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rpt_done |-> idx_r == (eng_r ? 5'(BASE_BYTES + 2 * NGATE - 1) : 5'(BASE_BYTES - 1)))
        else $error("report length wrong");
    a_wl_back: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wl_back |=> wireless_en_o) else $error("wireless not re-enabled");
    a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        |(irq_stat_r & irq_mask_r) |=> irq_o) else $error("irq not raised");
    c_arrive: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $rose(presence_o));
    c_leave: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $fell(presence_o));
    c_eng_rpt: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) rpt_done && eng_r);
    c_wl_back: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) wl_back);
endmodule // presence_decision_output
`default_nettype wire

/* verif/uart_host.sv */
// Purpose: Host side serial receiver model for the presence block
// Assumes: 8N1 framing, bit time given in system clock cycles
// Notes:   Samples mid-bit, so small divisor rounding is tolerated
`timescale 1ns/1ps
`default_nettype none
module uart_host #(
    parameter int BIT = 10
) (
    input  wire logic clk_sys_i,
    input  wire logic rx_i
);
    logic [7:0] byte_q[$];
    int         frame_err = 0;
    logic [7:0] sh;
    ////////////////////////////////////////////////////////////////
    initial forever
    begin
        @(negedge rx_i);
        repeat (BIT / 2) @(posedge clk_sys_i);
        if (rx_i !== 1'b0) frame_err++;
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge clk_sys_i);
            sh[i] = rx_i;
        end
        repeat (BIT) @(posedge clk_sys_i);
        if (rx_i !== 1'b1) frame_err++;
        byte_q.push_back(sh);
    end
endmodule // uart_host
`default_nettype wire

/* verif/tb.sv */
// Purpose: Register level test of presence decision and reporting
// Assumes: Short second, window and bit time set by parameters
// Notes:   Serial bytes are collected by the host model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module tb;
    import presence_pkg::*;
    logic        clk_sys_i = 0;
    logic        rst_n_i = 0;
    logic [7:0]  addr_i = '0;
    logic [31:0] wdata_i = '0;
    logic        wr_i = 0;
    logic        rd_i = 0;
    logic [31:0] rdata_o;
    logic [62:0] move_energy_i = '0;
    logic [62:0] static_energy_i = '0;
    logic        energy_valid_i = 0;
    logic        power_on_i = 0;
    logic        presence_o, uart_tx_o, wireless_en_o, irq_o;
    logic [62:0] m, s;
    int          fails = 0;
    int          checks_done = 0;
    int          cycles = 0;
    ////////////////////////////////////////////////////////////////
    presence_decision_output #(.SEC_CYC(50), .PWR_CYC(500), .BAUD(5_000_000)) u_dut (
        .clk_sys_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .move_energy_i,
        .static_energy_i, .energy_valid_i, .power_on_i, .presence_o, .uart_tx_o, .wireless_en_o, .irq_o);
    uart_host #(.BIT(10)) u_host (.clk_sys_i, .rx_i(uart_tx_o));
    initial forever #10 clk_sys_i = ~clk_sys_i;
    ////////////////////////////////////////////////////////////////
    task automatic chk(logic [31:0] g, logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic rc(logic [7:0] a, logic [31:0] e, logic [31:0] msk = 32'hffffffff);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        `CHK(rdata_o & msk, e);
    endtask
    function automatic logic [62:0] eg(int g, int v);
        eg = '0;
        eg[7*g +: 7] = 7'(v);
    endfunction
    task automatic feed(logic [62:0] mv, logic [62:0] st);
        @(posedge clk_sys_i);
        move_energy_i <= mv;
        static_energy_i <= st;
        energy_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        energy_valid_i <= 1'b0;
        cyc(1);
    endtask
    task automatic pw();
        @(posedge clk_sys_i);
        power_on_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        power_on_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
    endtask
    task automatic finish_test();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            finish_test();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        #1;
        `CHK(presence_o, 0);
        `CHK(wireless_en_o, 1);
        `CHK(uart_tx_o, 1);
        wr(ADR_CTRL, 32'h10);
        rc(ADR_MOVE_MAX, 8);
        rc(ADR_ABS_SEC, 5);
        for (int g = 0; g < 9; g++) rc(ADR_SENS_BASE + 8'(4*g), 50);
        wr(ADR_MOVE_MAX, 9);
        rc(ADR_MOVE_MAX, 8);
        wr(ADR_STAT_MAX, 0);
        rc(ADR_STAT_MAX, 1);
        wr(ADR_MOVE_MAX, 2);
        wr(ADR_SENS_BASE + 8'h04, 20);
        wr(ADR_ABS_SEC, 2);
        wr(ADR_IRQ_MASK, 32'hf);
        feed(eg(1, 20), '0);
        `CHK(presence_o, 0);
        feed(eg(3, 99), '0);
        `CHK(presence_o, 0);
        feed(eg(1, 21), '0);
        `CHK(presence_o, 1);
        rc(ADR_STATUS, 32'h105, 32'hf07);
        `CHK(irq_o, 1);
        wr(ADR_IRQ_STAT, 32'hf);
        cyc(2);
        `CHK(irq_o, 0);
        // Second hit lands late so only a restarted hold keeps presence
        feed(eg(1, 21), '0);
        cyc(88);
        feed(eg(1, 21), '0);
        cyc(45);
        `CHK(presence_o, 1);
        cyc(60);
        `CHK(presence_o, 0);
        cyc(2);
        `CHK(irq_o, 1);
        wr(ADR_IRQ_STAT, 32'hf);
        wr(ADR_IRQ_MASK, 32'h0);
        feed('0, eg(0, 60));
        `CHK(irq_o, 0);
        rc(ADR_STATUS, 32'h6, 32'hf007);
        feed(eg(2, 60), eg(0, 60));
        rc(ADR_STATUS, 32'h205, 32'hff07);
        wr(ADR_SENS_BASE, 100);
        cyc(110);
        feed(eg(0, 100), eg(0, 100));
        `CHK(presence_o, 0);
        wr(ADR_CTRL, 32'h3);
        wr(ADR_MOVE_MAX, 5);
        rc(ADR_MOVE_MAX, 0);
        wr(ADR_ABS_SEC, 7);
        rc(ADR_ABS_SEC, 0);
        m = eg(0, 9) | eg(1, 21) | eg(8, 100);
        s = eg(0, 60) | eg(7, 1);
        feed(m, s);
        cyc(2600);
        `CHK(u_host.byte_q.size(), 21);
        `CHK(u_host.byte_q[0], TGT_MOVING);
        `CHK(u_host.byte_q[1], 1);
        `CHK(u_host.byte_q[2], 0);
        for (int g = 0; g < 9; g++)
        begin
            `CHK(u_host.byte_q[3+g], m[7*g +: 7]);
            `CHK(u_host.byte_q[12+g], s[7*g +: 7]);
        end
        u_host.byte_q.delete();
        wr(ADR_CTRL, 32'h1);
        feed(m, s);
        cyc(500);
        `CHK(u_host.byte_q.size(), 3);
        `CHK(u_host.frame_err, 0);
        wr(ADR_CTRL, 32'h0);
        rc(ADR_MOVE_MAX, 2);
        wr(ADR_CTRL, 32'h8);
        cyc(2);
        `CHK(wireless_en_o, 0);
        wr(ADR_CTRL, 32'h4);
        cyc(2);
        `CHK(wireless_en_o, 1);
        wr(ADR_CTRL, 32'h8);
        repeat (5) pw();
        cyc(600);
        repeat (5) pw();
        cyc(5);
        `CHK(wireless_en_o, 0);
        pw();
        cyc(5);
        `CHK(wireless_en_o, 1);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rc(ADR_MOVE_MAX, 2);
        rc(ADR_ABS_SEC, 2);
        finish_test();
    end
endmodule // tb
`default_nettype wire
